// ---- port_pin_control_s_m.v ----
/*
  Pin control for port S (4 pins: pull enable, pull polarity, open drain)
  and port M (6 pins: data, pin input, direction, reduced drive), APB slave.
  Assumes port S data and direction come from elsewhere as levels, and that
  peripheral channel enables and the serial peripheral's pin directions are
  levels synchronous to pclk.
*/
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "port_ctl_regs.vh"

module port_pin_control_s_m (
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // port S: data and direction owned by other logic
  input wire [3:0] port_s_out_data,
  input wire [3:0] port_s_direction,
  output reg [3:0] port_s_pin_o,
  output reg [3:0] port_s_pin_oe,
  output reg [3:0] port_s_pull_up_en,
  output reg [3:0] port_s_pull_down_en,
  // port M pins
  input wire [5:0] port_m_pin_i,
  output reg [5:0] port_m_pin_o,
  output reg [5:0] port_m_pin_oe,
  output reg [5:0] port_m_reduced_drive,
  // peripheral overrides
  input wire [5:0] chan_tx_en,
  input wire [5:0] chan_rx_en,
  input wire [5:0] chan_tx_data,
  input wire spi_en,
  input wire [3:0] spi_pin_dir,
  input wire [3:0] spi_pin_data
);

  // control registers
  reg [3:0] ps_pull_en_r;
  reg [3:0] ps_pull_pol_r;
  reg [3:0] ps_open_drain_r;
  reg [5:0] pm_data_r;
  reg [5:0] pm_dir_r;
  reg [5:0] pm_drive_r;

  wire [5:0] pm_pin_sync;

  reg [31:0] rdata_nxt;
  reg err_nxt;
  reg [5:0] pm_dir_eff;
  reg [5:0] pm_out_val;
  reg [3:0] ps_pin_o_nxt;
  reg [3:0] ps_pin_oe_nxt;
  reg [3:0] ps_pu_nxt;
  reg [3:0] ps_pd_nxt;
  reg [5:0] pm_pin_o_nxt;
  reg [5:0] pm_pin_oe_nxt;
  reg [5:0] pm_drive_nxt;

  integer i;
  integer j;

  // pin owners, in falling priority
  localparam [1:0] OWN_RX = 2'b00;
  localparam [1:0] OWN_TX = 2'b01;
  localparam [1:0] OWN_SPI = 2'b10;
  localparam [1:0] OWN_REG = 2'b11;

  // receive beats transmit beats the serial peripheral, which beats
  // the direction register
  function [1:0] pin_owner;
    input rx_on;
    input tx_on;
    input spi_on;
    input upper;
    begin
      if (rx_on)
        pin_owner = OWN_RX;
      else if (tx_on)
        pin_owner = OWN_TX;
      else if (spi_on && upper)
        pin_owner = OWN_SPI;
      else
        pin_owner = OWN_REG;
    end
  endfunction

  // pull-up wanted by a port S pin that may carry one
  function ps_pull_up;
    input en;
    input pol;
    begin
      ps_pull_up = en & ~pol;
    end
  endfunction

  // pull-downs are legal on inputs only
  function ps_pull_down;
    input en;
    input pol;
    input is_input;
    begin
      ps_pull_down = en & pol & is_input;
    end
  endfunction

  // data read: latch where the direction bit says output, pin otherwise
  function [5:0] pm_read_merge;
    input [5:0] latch;
    input [5:0] pins;
    input [5:0] dir;
    begin
      pm_read_merge = (latch & dir) | (pins & ~dir);
    end
  endfunction

  // index of a decoded register, or 8'hff when the address maps nowhere
  function [7:0] reg_index;
    input [7:0] addr;
    begin
      if (addr[1:0] != 2'b00)
        reg_index = 8'hff;
      else begin
        case ({2'b00, addr[7:2]})
          `IDX_PS_PULL_EN: reg_index = `IDX_PS_PULL_EN;
          `IDX_PS_PULL_POL: reg_index = `IDX_PS_PULL_POL;
          `IDX_PS_OPEN_DRAIN: reg_index = `IDX_PS_OPEN_DRAIN;
          `IDX_PM_DATA: reg_index = `IDX_PM_DATA;
          `IDX_PM_PIN_IN: reg_index = `IDX_PM_PIN_IN;
          `IDX_PM_DIR: reg_index = `IDX_PM_DIR;
          `IDX_PM_DRIVE: reg_index = `IDX_PM_DRIVE;
          default: reg_index = 8'hff;
        endcase
      end
    end
  endfunction

  wire setup_phase = psel & ~penable;
  wire access_done = psel & penable & pready;
  wire [7:0] acc_idx = reg_index(paddr);
  wire wr_now = access_done & pwrite;

  pin_sync2 #(
    .WIDTH(`PM_WIDTH)
  ) u_pm_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(port_m_pin_i),
    .q(pm_pin_sync)
  );

  // effective port M direction; channel enables beat the direction register
  always @* begin
    for (i = 0; i < `PM_WIDTH; i = i + 1) begin
      case (pin_owner(chan_rx_en[i], chan_tx_en[i], spi_en, (i >= `PM_UPPER_LSB)))
        OWN_RX: begin
          pm_dir_eff[i] = 1'b0;
          pm_out_val[i] = pm_data_r[i];
        end
        OWN_TX: begin
          pm_dir_eff[i] = 1'b1;
          pm_out_val[i] = chan_tx_data[i];
        end
        OWN_SPI: begin
          pm_dir_eff[i] = spi_pin_dir[i-`PM_UPPER_LSB];
          pm_out_val[i] = spi_pin_data[i-`PM_UPPER_LSB];
        end
        default: begin
          pm_dir_eff[i] = pm_dir_r[i];
          pm_out_val[i] = pm_data_r[i];
        end
      endcase
    end
  end

  // port M pad controls
  always @* begin
    pm_pin_o_nxt = pm_out_val;
    pm_pin_oe_nxt = pm_dir_eff;
    pm_drive_nxt = pm_drive_r & pm_dir_eff;
  end

  // port S pad controls
  always @* begin
    for (j = 0; j < `PS_WIDTH; j = j + 1) begin
      if (!port_s_direction[j]) begin
        // input: open-drain bit plays no part
        ps_pin_oe_nxt[j] = 1'b0;
        ps_pin_o_nxt[j] = 1'b0;
        ps_pu_nxt[j] = ps_pull_up(ps_pull_en_r[j], ps_pull_pol_r[j]);
        ps_pd_nxt[j] = ps_pull_down(ps_pull_en_r[j], ps_pull_pol_r[j], 1'b1);
      end else if (ps_open_drain_r[j]) begin
        // drive low only, float for a one
        ps_pin_oe_nxt[j] = ~port_s_out_data[j];
        ps_pin_o_nxt[j] = 1'b0;
        // pull-down is not allowed on an open-drain output
        ps_pu_nxt[j] = ps_pull_up(ps_pull_en_r[j], ps_pull_pol_r[j]);
        ps_pd_nxt[j] = ps_pull_down(ps_pull_en_r[j], ps_pull_pol_r[j], 1'b0);
      end else begin
        // push-pull: pulls stay off whatever the registers hold
        ps_pin_oe_nxt[j] = 1'b1;
        ps_pin_o_nxt[j] = port_s_out_data[j];
        ps_pu_nxt[j] = 1'b0;
        ps_pd_nxt[j] = 1'b0;
      end
    end
  end

  // read mux, sampled in the setup cycle so data is ready in the access cycle
  always @* begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    case (acc_idx)
      `IDX_PS_PULL_EN: rdata_nxt[3:0] = ps_pull_en_r;
      `IDX_PS_PULL_POL: rdata_nxt[3:0] = ps_pull_pol_r;
      `IDX_PS_OPEN_DRAIN: rdata_nxt[3:0] = ps_open_drain_r;
      // data reads follow the direction register bit, not the override
      `IDX_PM_DATA: rdata_nxt[5:0] = pm_read_merge(pm_data_r, pm_pin_sync, pm_dir_r);
      `IDX_PM_PIN_IN: rdata_nxt[5:0] = pm_pin_sync;
      `IDX_PM_DIR: rdata_nxt[5:0] = pm_dir_r;
      `IDX_PM_DRIVE: rdata_nxt[5:0] = pm_drive_r;
      default: err_nxt = 1'b1;
    endcase
  end

  // apb handshake: one access cycle, no wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // read data and error stand only in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      pslverr <= err_nxt;
      prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
    end else begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // one write strobe per register; the input register has none,
  // so writes to it vanish without an error
  wire wr_ps_pull_en = wr_now & (acc_idx == `IDX_PS_PULL_EN);
  wire wr_ps_pull_pol = wr_now & (acc_idx == `IDX_PS_PULL_POL);
  wire wr_ps_open_drain = wr_now & (acc_idx == `IDX_PS_OPEN_DRAIN);
  wire wr_pm_data = wr_now & (acc_idx == `IDX_PM_DATA);
  wire wr_pm_dir = wr_now & (acc_idx == `IDX_PM_DIR);
  wire wr_pm_drive = wr_now & (acc_idx == `IDX_PM_DRIVE);

  // register writes land at the completing access edge only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_pull_en_r <= `RST_PS_PULL_EN;
    end else if (wr_ps_pull_en) begin
      ps_pull_en_r <= pwdata[3:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_pull_pol_r <= `RST_PS_PULL_POL;
    end else if (wr_ps_pull_pol) begin
      ps_pull_pol_r <= pwdata[3:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_open_drain_r <= `RST_PS_OPEN_DRAIN;
    end else if (wr_ps_open_drain) begin
      ps_open_drain_r <= pwdata[3:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_data_r <= `RST_PM_DATA;
    end else if (wr_pm_data) begin
      pm_data_r <= pwdata[5:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_dir_r <= `RST_PM_DIR;
    end else if (wr_pm_dir) begin
      pm_dir_r <= pwdata[5:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_drive_r <= `RST_PM_DRIVE;
    end else if (wr_pm_drive) begin
      pm_drive_r <= pwdata[5:0];
    end
  end

  // pad outputs all come from flops; one cycle after the controlling change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_s_pin_o <= 4'h0;
      port_s_pin_oe <= 4'h0;
      port_s_pull_up_en <= 4'h0;
      port_s_pull_down_en <= 4'h0;
    end else begin
      port_s_pin_o <= ps_pin_o_nxt;
      port_s_pin_oe <= ps_pin_oe_nxt;
      port_s_pull_up_en <= ps_pu_nxt;
      port_s_pull_down_en <= ps_pd_nxt;
    end
  end

  // port M pads released during reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_m_pin_o <= 6'h00;
      port_m_pin_oe <= 6'h00;
      port_m_reduced_drive <= 6'h00;
    end else begin
      port_m_pin_o <= pm_pin_o_nxt;
      port_m_pin_oe <= pm_pin_oe_nxt;
      port_m_reduced_drive <= pm_drive_nxt;
    end
  end

endmodule // port_pin_control_s_m

`default_nettype wire

// ---- port_ctl_regs.vh ----
/*
  Register map, reset values and timing figures for the port S / port M
  pin control block.
  Assumes an APB slave with 32-bit data and one aligned word per register.
*/
`ifndef PORT_CTL_REGS_VH
`define PORT_CTL_REGS_VH

// register indices; byte address is four times the index
`define IDX_PS_PULL_EN 8'h0c
`define IDX_PS_PULL_POL 8'h0d
`define IDX_PS_OPEN_DRAIN 8'h0e
`define IDX_PM_DATA 8'h10
`define IDX_PM_PIN_IN 8'h11
`define IDX_PM_DIR 8'h12
`define IDX_PM_DRIVE 8'h13

`define PS_WIDTH 4
`define PM_WIDTH 6
`define PM_UPPER_LSB 2

`define RST_PS_PULL_EN 4'hf
`define RST_PS_PULL_POL 4'h0
`define RST_PS_OPEN_DRAIN 4'h0
`define RST_PM_DATA 6'h00
`define RST_PM_DIR 6'h00
`define RST_PM_DRIVE 6'h00

// synchronizer depth in bus cycles
`define SYNC_STAGES 2

`endif

// ---- pin_sync2.v ----
/*
  Two-stage level synchronizer for a bundle of pin inputs.
  Assumes pins are sampled on pclk; first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
  parameter WIDTH = 6
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule // pin_sync2

`default_nettype wire

// ---- port_pin_control_s_m_assertions.sv ----
/* assertion checker for the port S / port M pin control block;
   bound to its top module, one clock pclk */
`timescale 1ns/1ps
`default_nettype none
module pin_ctl_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] port_s_out_data,
  input wire logic [3:0] port_s_direction,
  input wire logic [3:0] port_s_pin_o,
  input wire logic [3:0] port_s_pin_oe,
  input wire logic [3:0] port_s_pull_up_en,
  input wire logic [3:0] port_s_pull_down_en,
  input wire logic [5:0] port_m_pin_oe,
  input wire logic [5:0] port_m_reduced_drive,
  input wire logic [5:0] chan_tx_en,
  input wire logic [5:0] chan_rx_en
);
  logic up_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // $past still sees reset-time inputs on the first edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) up_r <= 1'b0;
    else up_r <= 1'b1;
  end
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready not one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_so; up_r |-> port_s_pin_o == (port_s_pin_oe & $past(port_s_out_data)); endproperty
  a_so: assert property (p_so) else $error("port s pad value");
  property p_sin; up_r |-> (port_s_pin_oe & ~$past(port_s_direction)) == 4'h0; endproperty
  a_sin: assert property (p_sin) else $error("port s input driven");
  property p_pp; up_r |-> (port_s_pull_up_en & port_s_pin_o & $past(port_s_direction)) == 4'h0; endproperty
  a_pp: assert property (p_pp) else $error("pull on push-pull");
  property p_pd; up_r |-> (port_s_pull_down_en & $past(port_s_direction)) == 4'h0; endproperty
  a_pd: assert property (p_pd) else $error("pull-down on output");
  property p_rx; up_r |-> (port_m_pin_oe & $past(chan_rx_en)) == 6'h00; endproperty
  a_rx: assert property (p_rx) else $error("rx pin driven");
  property p_tx; up_r |-> ($past(chan_tx_en) & ~$past(chan_rx_en) & ~port_m_pin_oe) == 6'h00; endproperty
  a_tx: assert property (p_tx) else $error("tx pin not driven");
  property p_rd; (port_m_reduced_drive & ~port_m_pin_oe) == 6'h00; endproperty
  a_rd: assert property (p_rd) else $error("reduced drive on input");
endmodule // pin_ctl_chk
bind port_pin_control_s_m pin_ctl_chk chk_u (.*);
`default_nettype wire

// ---- pin_pad_model.sv ----
/* port M pads: resolves pin levels from the block's drivers;
   undriven pads follow the bench's external level */
`timescale 1ns/1ps
`default_nettype none
module pin_pad_model (
  input wire logic [5:0] pin_o,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] ext_lvl,
  input wire logic shorted,
  output logic [5:0] pin_i
);
  // a short fights the driver, as an overloaded pad would
  assign pin_i = (pin_oe & (shorted ? ~pin_o : pin_o)) | (~pin_oe & ext_lvl);
endmodule // pin_pad_model
`default_nettype wire

// ---- port_pin_control_s_m_tb_top.sv ----
/* self-checking bench for the pin control block;
   apb master tasks, pad model on port M */
`timescale 1ns/1ps
`default_nettype none
module port_pin_control_s_m_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sh = 1'b0, spi_en = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [3:0] s_d = 4'h0, s_dir = 4'h0, spi_dir = 4'h0, spi_d = 4'h0, s_o, s_oe, s_pu, s_pd;
  logic [5:0] ext = 6'h00, tx_en = 6'h00, rx_en = 6'h00, tx_d = 6'h00, m_i, m_o, m_oe, m_rd;
  int fail_count = 0, comparisons = 0;
  always #4 pclk = ~pclk;
  port_pin_control_s_m dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_s_out_data(s_d), .port_s_direction(s_dir), .port_s_pin_o(s_o), .port_s_pin_oe(s_oe),
    .port_s_pull_up_en(s_pu), .port_s_pull_down_en(s_pd), .port_m_pin_i(m_i), .port_m_pin_o(m_o),
    .port_m_pin_oe(m_oe), .port_m_reduced_drive(m_rd), .chan_tx_en(tx_en), .chan_rx_en(rx_en),
    .chan_tx_data(tx_d), .spi_en(spi_en), .spi_pin_dir(spi_dir), .spi_pin_data(spi_d));
  pin_pad_model pad_u (.pin_o(m_o), .pin_oe(m_oe), .ext_lvl(ext), .shorted(sh), .pin_i(m_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
                     input logic xe);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) chk(prdata, x);
    chk({31'h0, pslverr}, {31'h0, xe});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset;
    chk({s_pu, s_pd}, 8'hf0);
    acc(1'b0, 8'h30, 32'h0, 32'hf, 1'b0);
    acc(1'b0, 8'h38, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 8'h50, 32'h0, 32'h0, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_regs;
    logic [7:0] ad [5] = '{8'h30, 8'h34, 8'h38, 8'h48, 8'h4c};
    foreach (ad[i]) acc(1'b1, ad[i], 32'hffffffff, 32'h0, 1'b0);
    foreach (ad[i]) acc(1'b0, ad[i], 32'h0, i < 3 ? 32'hf : 32'h3f, 1'b0);
    acc(1'b1, 8'h44, 32'h3f, 32'h0, 1'b0);
    acc(1'b0, 8'h44, 32'h0, 32'h0, 1'b0);
    $display("register test done");
  endtask
  task automatic t_port_s;
    acc(1'b1, 8'h34, 32'h3, 32'h0, 1'b0);
    acc(1'b1, 8'h38, 32'h5, 32'h0, 1'b0);
    s_dir <= 4'h6;
    s_d <= 4'hf;
    repeat (2) @(posedge pclk);
    chk({s_pu, s_pd, s_oe, s_o}, 16'hc122);
    s_d <= 4'h0;
    repeat (2) @(posedge pclk);
    chk({s_oe, s_o}, 8'h60);
    acc(1'b1, 8'h30, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    chk({s_pu, s_pd}, 8'h00);
    $display("port s test done");
  endtask
  task automatic t_port_m;
    acc(1'b1, 8'h48, 32'h0f, 32'h0, 1'b0);
    acc(1'b1, 8'h40, 32'h2a, 32'h0, 1'b0);
    ext <= 6'h15;
    repeat (3) @(posedge pclk);
    chk({m_oe, m_rd, m_o & m_oe}, {6'h0f, 6'h0f, 6'h0a});
    acc(1'b0, 8'h40, 32'h0, 32'h1a, 1'b0);
    acc(1'b0, 8'h44, 32'h0, 32'h1a, 1'b0);
    sh <= 1'b1;
    repeat (3) @(posedge pclk);
    acc(1'b0, 8'h44, 32'h0, 32'h15, 1'b0);
    acc(1'b0, 8'h40, 32'h0, 32'h1a, 1'b0);
    sh <= 1'b0;
    acc(1'b1, 8'h48, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    chk(m_oe, 6'h00);
    acc(1'b0, 8'h40, 32'h0, 32'h15, 1'b0);
    $display("port m test done");
  endtask
  task automatic t_override;
    acc(1'b1, 8'h48, 32'h02, 32'h0, 1'b0);
    tx_en <= 6'h03;
    rx_en <= 6'h02;
    tx_d <= 6'h01;
    spi_en <= 1'b1;
    spi_dir <= 4'h3;
    spi_d <= 4'h1;
    repeat (2) @(posedge pclk);
    chk({m_oe, m_o & m_oe, m_rd}, {6'h0d, 6'h05, 6'h0d});
    tx_en <= 6'h00;
    rx_en <= 6'h00;
    spi_en <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(m_oe, 6'h02);
    $display("override test done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset;
    t_regs;
    t_port_s;
    t_port_m;
    t_override;
    tally_and_finish;
  end
  initial begin
    #20000;
    fail_count++;
    tally_and_finish;
  end
endmodule // port_pin_control_s_m_tb_top
`default_nettype wire
